// ==== adc_ctrl_consts.vh ====
// Constants for the converter control block: register offsets, field positions, resets, timing.
// Included by the control block and its result store; definitions only.
`ifndef ADC_CTRL_CONSTS_VH
`define ADC_CTRL_CONSTS_VH

// Register offsets (8-bit registers on a plain port)
`define OFS_SC1        3'h0
`define OFS_SC2        3'h1
`define OFS_RES_HI     3'h2
`define OFS_RES_LO     3'h3
`define OFS_CMP_HI     3'h4
`define OFS_CMP_LO     3'h5
`define OFS_CFG        3'h6
`define OFS_SYSOPT     3'h7

// Control register one fields
`define SC1_DONE_BIT   7
`define SC1_IEN_BIT    6
`define SC1_CONT_BIT   5
`define SC1_CH_HI      4
`define SC1_CH_LO      0

// Control register two fields
`define SC2_ACT_BIT    7
`define SC2_TRG_BIT    6
`define SC2_CFE_BIT    5
`define SC2_CGT_BIT    4

// Configuration field: resolution mode in bits 3:2
`define CFG_MODE_HI    3
`define CFG_MODE_LO    2
`define MODE_8         2'h0
`define MODE_12        2'h1
`define MODE_10        2'h2

// System options: trigger source select bit
`define SYSOPT_TSS_BIT 0

// Channel codes
`define CH_DISABLED    5'h1f
`define CH_REFH        5'h1d
`define CH_REFL        5'h1e

// Reset values
`define SC1_RESET      8'h1f
`define SC2_RESET      8'h00
`define CFG_RESET      8'h00
`define SYSOPT_RESET   8'h00

// Conversion time in ns as a nominal figure; not used by the core model, which answers after DLY cycles
`define CONV_TIME_NS   2000
`define CLK_PERIOD_NS  8

`endif

// ==== result_store.v ====
// Result store: holds the converted result and its high/low register images.
// Assumes the control block gives one-cycle load pulses and read pulses.
`timescale 1ns/1ps
`include "adc_ctrl_consts.vh"

module result_store #(
  parameter WIDTH = 12
) (
  // Clock and reset
  input  wire             clock,
  input  wire             srst,
  // Load from converter
  input  wire             load,
  input  wire [WIDTH-1:0] load_data,
  input  wire [1:0]       mode,
  // Register reads
  input  wire             rd_hi,
  input  wire             rd_lo,
  output reg  [7:0]       hi_r,
  output reg  [7:0]       lo_r
);

  reg lock_r;
  reg [WIDTH-1:0] fmt;

  // Right-justify to the chosen resolution, upper bits cleared
  always @* begin
    case (mode)
      `MODE_12: fmt = load_data;
      `MODE_10: fmt = {2'h0, load_data[WIDTH-1:2]};
      default:  fmt = {4'h0, load_data[WIDTH-1:4]};
    endcase
  end

  // Reading the high byte locks the store until the low byte is read; 8-bit mode has no lock
  always @(posedge clock) begin
    if (srst) begin
      hi_r   <= 8'h00;
      lo_r   <= 8'h00;
      lock_r <= 1'b0;
    end else begin
      if (rd_lo)
        lock_r <= 1'b0;
      else if (rd_hi && mode != `MODE_8)
        lock_r <= 1'b1;
      if (load && !(lock_r && !rd_lo)) begin
        hi_r <= {4'h0, fmt[11:8]};
        lo_r <= fmt[7:0];
      end
    end
  end

endmodule

// ==== adc_conversion_control.v ====
// Conversion control: trigger selection, start and abort, single and continuous runs,
// done flag and interrupt, compare, power-down. Registers on a plain 8-bit port.
// Assumes the analog core answers each start with a done pulse and a 12-bit result.
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "adc_ctrl_consts.vh"

module adc_conversion_control #(
  parameter RES_W = 12
) (
  // Clock and reset
  input  wire             clock,
  input  wire             srst,
  // Register port
  input  wire [2:0]       addr,
  input  wire [7:0]       wdata,
  input  wire             wr,
  input  wire             rd,
  output reg  [7:0]       rdata_r,
  // Trigger sources
  input  wire             rtc_overflow,
  input  wire             irq_pin,
  // Analog core
  output reg              conv_start_r,
  output reg              conv_abort_r,
  output reg  [4:0]       channel_select_r,
  output reg              core_power_r,
  input  wire             conv_done,
  input  wire [RES_W-1:0] conv_result,
  // Interrupt
  output reg              done_irq_r
);

  // Registers
  reg [7:0] conv_status_control_one_r;
  reg [7:0] sc2_r;
  reg [7:0] cfg_r;
  reg [7:0] system_options_reg_two_r;
  reg [7:0] cmp_hi_r;
  reg [7:0] cmp_lo_r;
  reg       conv_active_r;
  reg       trig_s1_r;
  reg       trig_s2_r;
  reg       trig_s3_r;
  reg       run_armed_r;

  wire [7:0] res_hi;
  wire [7:0] res_lo;

  wire wr_sc1 = wr && addr == `OFS_SC1;
  wire rd_lo  = rd && addr == `OFS_RES_LO;
  wire rd_hi  = rd && addr == `OFS_RES_HI;

  wire       done_flag   = conv_status_control_one_r[`SC1_DONE_BIT];
  wire       irq_en      = conv_status_control_one_r[`SC1_IEN_BIT];
  wire       continuous  = conv_status_control_one_r[`SC1_CONT_BIT];
  wire [4:0] channel     = conv_status_control_one_r[`SC1_CH_HI:`SC1_CH_LO];
  wire       hw_mode     = sc2_r[`SC2_TRG_BIT];
  wire       cmp_en      = sc2_r[`SC2_CFE_BIT];
  wire       cmp_ge      = sc2_r[`SC2_CGT_BIT];
  wire [1:0] mode        = cfg_r[`CFG_MODE_HI:`CFG_MODE_LO];

  // Trigger source mux; the core keeps counting in low-power modes so no mode gating here
  wire hw_conv_trigger = system_options_reg_two_r[`SYSOPT_TSS_BIT] ? irq_pin : rtc_overflow;

  // Two-stage synchroniser plus edge stage; the first stage feeds only the second
  always @(posedge clock) begin
    if (srst) begin
      trig_s1_r <= 1'b0;
      trig_s2_r <= 1'b0;
      trig_s3_r <= 1'b0;
    end else begin
      trig_s1_r <= hw_conv_trigger;
      trig_s2_r <= trig_s1_r;
      trig_s3_r <= trig_s2_r;
    end
  end

  wire hw_edge = trig_s2_r && !trig_s3_r;

  // Compare on the resolution-scaled result
  reg [11:0] res_scaled;
  reg [11:0] cmp_val;
  always @* begin
    case (mode)
      `MODE_12: begin
        res_scaled = conv_result;
        cmp_val    = {cmp_hi_r[3:0], cmp_lo_r};
      end
      `MODE_10: begin
        res_scaled = {2'h0, conv_result[RES_W-1:2]};
        cmp_val    = {2'h0, cmp_hi_r[1:0], cmp_lo_r};
      end
      default: begin
        res_scaled = {4'h0, conv_result[RES_W-1:4]};
        cmp_val    = {4'h0, cmp_lo_r};
      end
    endcase
  end

  wire cmp_true = cmp_ge ? (res_scaled >= cmp_val) : (res_scaled < cmp_val);
  wire finish   = conv_done && conv_active_r && !wr_sc1;
  wire accept   = finish && (!cmp_en || cmp_true);

  // Start decision: software start on a write, hardware start on a trigger edge
  wire wr_ch_ok = wdata[`SC1_CH_HI:`SC1_CH_LO] != `CH_DISABLED;
  wire sw_start = wr_sc1 && !hw_mode && wr_ch_ok;
  wire hw_start = !wr_sc1 && hw_mode && hw_edge && channel != `CH_DISABLED && !conv_active_r;
  wire repeat_start = finish && continuous && run_armed_r && channel != `CH_DISABLED;

  // Control one: a write clears the done flag and wins over its set; the set wins over the low-byte read clear in the same cycle
  always @(posedge clock) begin
    if (srst) begin
      conv_status_control_one_r <= `SC1_RESET;
    end else begin
      if (wr_sc1)
        conv_status_control_one_r <= {1'b0, wdata[6:0]};
      else if (accept)
        conv_status_control_one_r[`SC1_DONE_BIT] <= 1'b1;
      else if (rd_lo)
        conv_status_control_one_r[`SC1_DONE_BIT] <= 1'b0;
    end
  end

  // Other writable registers
  always @(posedge clock) begin
    if (srst) begin
      sc2_r                    <= `SC2_RESET;
      cfg_r                    <= `CFG_RESET;
      system_options_reg_two_r <= `SYSOPT_RESET;
      cmp_hi_r                 <= 8'h00;
      cmp_lo_r                 <= 8'h00;
    end else if (wr) begin
      case (addr)
        `OFS_SC2:    sc2_r <= {1'b0, wdata[6:4], 2'h0, wdata[1:0]};
        `OFS_CFG:    cfg_r <= wdata;
        `OFS_SYSOPT: system_options_reg_two_r <= wdata;
        `OFS_CMP_HI: cmp_hi_r <= wdata;
        `OFS_CMP_LO: cmp_lo_r <= wdata;
        default:     ;
      endcase
    end
  end

  // Conversion sequencing: active flag, arm for continuous runs, core start and abort
  always @(posedge clock) begin
    if (srst) begin
      conv_active_r    <= 1'b0;
      run_armed_r      <= 1'b0;
      conv_start_r     <= 1'b0;
      conv_abort_r     <= 1'b0;
      channel_select_r <= `CH_DISABLED;
      core_power_r     <= 1'b0;
    end else begin
      conv_start_r <= 1'b0;
      conv_abort_r <= 1'b0;
      if (wr_sc1) begin
        conv_abort_r     <= conv_active_r;
        conv_active_r    <= sw_start;
        run_armed_r      <= sw_start;
        conv_start_r     <= sw_start;
        channel_select_r <= wdata[`SC1_CH_HI:`SC1_CH_LO];
        core_power_r     <= sw_start;
      end else if (hw_start || repeat_start) begin
        conv_active_r    <= 1'b1;
        run_armed_r      <= 1'b1;
        conv_start_r     <= 1'b1;
        channel_select_r <= channel;
        core_power_r     <= 1'b1;
      end else if (finish) begin
        conv_active_r <= 1'b0;
        run_armed_r   <= continuous && hw_mode ? 1'b0 : run_armed_r;
        core_power_r  <= 1'b0;
      end
    end
  end

  // Interrupt level follows the done flag, set in the same cycle as the flag, while enable is high
  always @(posedge clock) begin
    if (srst)
      done_irq_r <= 1'b0;
    else
      done_irq_r <= (done_flag || (accept && !wr_sc1)) && irq_en && !(wr_sc1 || (rd_lo && !accept));
  end

  // Result store only updates on accepted conversions
  result_store #(
    .WIDTH(RES_W)
  ) u_store (
    .clock     (clock),
    .srst      (srst),
    .load      (accept),
    .load_data (conv_result),
    .mode      (mode),
    .rd_hi     (rd_hi),
    .rd_lo     (rd_lo),
    .hi_r      (res_hi),
    .lo_r      (res_lo)
  );

  // Read data, one cycle after the strobe; unmapped reads give zero
  always @(posedge clock) begin
    if (srst) begin
      rdata_r <= 8'h00;
    end else if (rd) begin
      case (addr)
        `OFS_SC1:    rdata_r <= conv_status_control_one_r;
        `OFS_SC2:    rdata_r <= {conv_active_r, sc2_r[6:0]};
        `OFS_RES_HI: rdata_r <= res_hi;
        `OFS_RES_LO: rdata_r <= res_lo;
        `OFS_CMP_HI: rdata_r <= cmp_hi_r;
        `OFS_CMP_LO: rdata_r <= cmp_lo_r;
        `OFS_CFG:    rdata_r <= cfg_r;
        `OFS_SYSOPT: rdata_r <= system_options_reg_two_r;
        default:     rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

endmodule

// ==== adc_conversion_control_props.sv ====
// Checker for the conversion control block, bound to its top module.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module adc_conversion_control_props (
  // Clock and reset
  input wire       clock,
  input wire       srst,
  // Register port
  input wire [2:0] addr,
  input wire [7:0] wdata,
  input wire       wr,
  // Core and interrupt side
  input wire       conv_start_r,
  input wire       conv_abort_r,
  input wire [4:0] channel_select_r,
  input wire       core_power_r,
  input wire       conv_done,
  input wire       done_irq_r
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  // A control one write, and one that selects a real channel
  sequence sc1_wr;
    wr && addr == 3'h0;
  endsequence
  sequence sc1_go;
    sc1_wr ##0 wdata[4:0] != 5'h1f;
  endsequence
  reset_state_a: assert property ($fell(srst) |-> channel_select_r == 5'h1f && !core_power_r && !done_irq_r)
    else $error("reset state wrong");
  write_start_a: assert property (sc1_go |=> conv_start_r && core_power_r)
    else $error("write did not start");
  park_code_a: assert property (sc1_wr ##0 wdata[4:0] == 5'h1f |=> !conv_start_r && !core_power_r)
    else $error("disabled code started or powered");
  channel_follow_a: assert property (sc1_wr |=> channel_select_r == $past(wdata[4:0]))
    else $error("channel not taken");
  abort_cause_a: assert property (conv_abort_r |-> $past(wr) && $past(addr) == 3'h0)
    else $error("abort without write");
  irq_rise_a: assert property ($rose(done_irq_r) |-> $past(conv_done))
    else $error("irq rose without done");
  irq_clear_a: assert property (sc1_wr |=> !done_irq_r)
    else $error("irq not cleared by write");
  start_pulse_a: assert property (conv_start_r && !$past(wr) |=> !conv_start_r)
    else $error("start longer than a cycle");
  start_power_a: assert property (conv_start_r |-> core_power_r)
    else $error("start while powered down");
endmodule

bind adc_conversion_control adc_conversion_control_props i_props (.clock, .srst, .addr, .wdata, .wr, .conv_start_r,
  .conv_abort_r, .channel_select_r, .core_power_r, .conv_done, .done_irq_r);

// ==== core_model.sv ====
// Behavioural converter core: answers each start with a done pulse DLY cycles later.
// Assumes start and abort are single-cycle pulses from the control block.
`timescale 1ns/1ps
module core_model #(
  parameter DLY = 20
) (
  // Clock and reset
  input  wire         clock,
  input  wire         srst,
  // Control from the block
  input  wire         conv_start_r,
  input  wire         conv_abort_r,
  input  wire [4:0]   channel_select_r,
  // Answer to the block
  output logic        conv_done,
  output logic [11:0] conv_result
);
  int cnt = 0;
  initial begin
    conv_done = 1'b0;
    conv_result = 12'h000;
  end
  // Start wins over abort so that a restarting write is not lost
  always @(posedge clock) begin
    conv_done <= 1'b0;
    conv_result <= ~conv_result; // Result means nothing away from the done pulse
    if (srst || (conv_abort_r && !conv_start_r))
      cnt <= 0;
    else if (conv_start_r)
      cnt <= DLY;
    else if (cnt == 1) begin
      cnt <= 0;
      conv_done <= 1'b1;
      conv_result <= {channel_select_r, 7'h23};
    end else if (cnt > 1)
      cnt <= cnt - 1;
  end
endmodule

// ==== adc_conversion_control_tb.sv ====
// Testbench for the conversion control block with a behavioural core.
// Assumes the core answers each start after 20 cycles with result {channel, 7'h23}.
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; $display("mismatch %0t %h %h", $time, g, e); end end
module adc_conversion_control_tb;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic [2:0]  addr = 3'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        rtc_overflow = 1'b0;
  logic        irq_pin = 1'b0;
  logic [7:0]  rdata_r;
  logic [4:0]  channel_select_r;
  logic [11:0] conv_result;
  logic        conv_start_r, conv_abort_r, core_power_r, conv_done, done_irq_r;
  int          mismatches = 0;
  int          checks = 0;
  int          dones = 0;
  int          cycles = 0;
  int          d0;
  adc_conversion_control #(.RES_W(12)) i_dut (.clock, .srst, .addr, .wdata, .wr, .rd, .rdata_r, .rtc_overflow,
    .irq_pin, .conv_start_r, .conv_abort_r, .channel_select_r, .core_power_r, .conv_done, .conv_result, .done_irq_r);
  core_model #(.DLY(20)) i_core (.clock, .srst, .conv_start_r, .conv_abort_r, .channel_select_r, .conv_done,
    .conv_result);
  initial forever #4 clock = ~clock;
  // Done pulses counted mid-cycle, away from the sampling edge
  always @(negedge clock) if (conv_done === 1'b1) dones++;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    @(posedge clock);
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rreg(input logic [2:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 `CHK(rdata_r, e)
    @(posedge clock);
  endtask
  // Bounded wait for the core's done pulse, then let the flag settle
  task automatic wait_done();
    repeat (60) begin
      @(posedge clock);
      if (conv_done === 1'b1) break;
    end
    repeat (2) @(posedge clock);
  endtask
  // Trigger held for several cycles must still start only once
  task automatic trig(input bit pin);
    if (pin) irq_pin <= 1'b1;
    else rtc_overflow <= 1'b1;
    repeat (5) @(posedge clock);
    irq_pin <= 1'b0;
    rtc_overflow <= 1'b0;
    repeat (40) @(posedge clock);
  endtask
  task automatic summarize();
    if (mismatches == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    rreg(3'h0, 8'h1f);
    rreg(3'h1, 8'h00);
    wreg(3'h6, 8'h04);
    wreg(3'h0, 8'h45);
    wait_done();
    `CHK(done_irq_r, 1'b1)
    `CHK(core_power_r, 1'b0)
    rreg(3'h0, 8'hc5);
    rreg(3'h2, 8'h02);
    rreg(3'h3, 8'ha3);
    rreg(3'h0, 8'h45);
    `CHK(done_irq_r, 1'b0)
    wreg(3'h0, 8'h03);
    rreg(3'h1, 8'h80);
    wreg(3'h0, 8'h04);
    wait_done();
    rreg(3'h3, 8'h23);
    rreg(3'h1, 8'h00);
    wreg(3'h0, 8'h27);
    d0 = dones;
    wait_done();
    wait_done();
    `CHK(dones - d0 > 1, 1'b1)
    wreg(3'h0, 8'h1f);
    repeat (50) @(posedge clock);
    rreg(3'h0, 8'h1f);
    `CHK(core_power_r, 1'b0)
    wreg(3'h4, 8'h01);
    wreg(3'h5, 8'h00);
    wreg(3'h1, 8'h20);
    wreg(3'h0, 8'h02);
    wait_done();
    rreg(3'h0, 8'h02);
    wreg(3'h1, 8'h30);
    wreg(3'h0, 8'h02);
    wait_done();
    rreg(3'h0, 8'h82);
    wreg(3'h1, 8'h40);
    d0 = dones;
    trig(1'b1);
    `CHK(dones - d0, 0)
    trig(1'b0);
    `CHK(dones - d0, 1)
    wreg(3'h7, 8'h01);
    trig(1'b1);
    `CHK(dones - d0, 2)
    trig(1'b0);
    `CHK(dones - d0, 2)
    // Sensor order: bandgap channel first, then the temperature channel, back in software mode
    wreg(3'h1, 8'h00);
    wreg(3'h0, 8'h1b);
    wait_done();
    rreg(3'h2, 8'h0d);
    rreg(3'h3, 8'ha3);
    wreg(3'h0, 8'h1a);
    wait_done();
    rreg(3'h3, 8'h23);
    summarize();
  end
endmodule
